// >>> common/qpd_pkg.sv
// constants for the quad pot serial command decoder
package qpd_pkg;
   // type identifier value is arbitrary
   localparam logic [3:0] QPD_TYPE_ID = 4'hC;
   localparam int QPD_STRAP_MSB = 1;
   localparam int QPD_STRAP_LSB = 0;
   localparam int QPD_WPTR_MSB = 1;
   localparam int QPD_WPTR_LSB = 0;
   localparam int QPD_TYPE_MSB = 7;
   localparam int QPD_TYPE_LSB = 4;
   localparam int QPD_ZERO_MSB = 3;
   localparam int QPD_ZERO_LSB = 2;
   localparam int QPD_OPC_MSB = 7;
   localparam int QPD_OPC_LSB = 4;
   localparam int QPD_SET_MSB = 3;
   localparam int QPD_SET_LSB = 2;
   localparam logic [7:0] QPD_WIPER_RST = 8'h00;
   localparam int QPD_CLK_MHZ = 125;
   localparam int QPD_WIPER_US = 10;
   localparam int QPD_WIPER_CYC = QPD_WIPER_US * QPD_CLK_MHZ;
   localparam int QPD_NVW_MS = 5;
   localparam int QPD_NVW_CYC = QPD_NVW_MS * 1000 * QPD_CLK_MHZ;
   typedef enum logic [1:0] {QPD_ADDR, QPD_INSTR, QPD_DATA, QPD_IGNORE} qpd_state_t;
endpackage : qpd_pkg

// >>> rtl/qpd_decode.sv
// serial command front end: address check, instruction decode, wiper and nv timing
// Functional notes
// - The first byte of each command is the address byte, whose top four bits must equal the type identifier.
// - The command goes on only if the address byte's two low bits equal the two strap pins.
// - A device whose strap address does not match takes no action on the instruction.
// - The second byte is the instruction byte, its top four bits being the opcode.
// - Instruction bits three and two select stored setting 0 to 3 in binary.
// - Instruction bits one and zero select one of four wiper position registers.
// - After power-up the wiper shows the position register within 10 us.
// - After an instruction changes a position register the wiper follows within 10 us.
// - At power-up each position register is loaded from that pot's stored setting 0.
// - Non-volatile commit of written stored settings starts when chip select goes high after any write opcode.
// - A stored setting change finishes within 5 ms and is reported in progress until then.
`timescale 1ns/10ps
module qpd_decode
   import qpd_pkg::*;
#(
   parameter int NVW_CYC = QPD_NVW_CYC
)
(
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   input wire logic SCK_I,
   input wire logic CS_N_I,
   input wire logic SI_I,
   input wire logic STRAP_ADDR_HI_I,
   input wire logic STRAP_ADDR_LO_I,
   input wire logic [7:0] STORED_SETTING_0_P0_I,
   input wire logic [7:0] STORED_SETTING_0_P1_I,
   input wire logic [7:0] STORED_SETTING_0_P2_I,
   input wire logic [7:0] STORED_SETTING_0_P3_I,
   input wire logic WIPER_WR_I,
   input wire logic [7:0] WIPER_WR_DATA_I,
   input wire logic NV_WRITE_DONE_I,
   output logic CMD_VALID_O,
   output logic [3:0] OPCODE_FIELD_O,
   output logic [1:0] SETTING_PTR_O,
   output logic [1:0] WIPER_PTR_O,
   output logic ADDR_MISMATCH_O,
   output logic SO_OE_O,
   output logic WRITE_PENDING_FLAG_O,
   output logic [7:0] WIPER_POS0_O,
   output logic [7:0] WIPER_POS1_O,
   output logic [7:0] WIPER_POS2_O,
   output logic [7:0] WIPER_POS3_O
);

   // ---------------- link domain (SCK) ----------------
   // cs reset clears the frame without needing an sck edge after the last bit;
   // system reset joins in so the first frame never starts from an unknown state
   qpd_state_t st_r, st_nxt;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [6:0] shf_r, shf_nxt;
   logic [7:0] instr_r, instr_nxt;
   logic cmd_tgl_r, cmd_tgl_nxt;
   logic [1:0] strap_s1_r, strap_s2_r;
   logic [7:0] byte_in;
   logic ign_r, ign_nxt;
   logic frame_rst;

   assign byte_in = {shf_r, SI_I};
   assign frame_rst = CS_N_I | ~RSTN_I;

   always_comb
   begin
      st_nxt = st_r;
      bit_cnt_nxt = bit_cnt_r + 3'd1;
      shf_nxt = byte_in[6:0];
      instr_nxt = instr_r;
      cmd_tgl_nxt = cmd_tgl_r;
      case (st_r)
         QPD_ADDR:
         begin
            if (bit_cnt_r == 3'd7)
            begin
               if (byte_in[QPD_TYPE_MSB:QPD_TYPE_LSB] == QPD_TYPE_ID &&
                   byte_in[QPD_ZERO_MSB:QPD_ZERO_LSB] == 2'b00 &&
                   byte_in[QPD_STRAP_MSB:QPD_STRAP_LSB] == strap_s2_r)
                  st_nxt = QPD_INSTR;
               else
                  st_nxt = QPD_IGNORE;
            end
         end
         QPD_INSTR:
         begin
            if (bit_cnt_r == 3'd7)
            begin
               instr_nxt = byte_in;
               cmd_tgl_nxt = ~cmd_tgl_r;
               st_nxt = QPD_DATA;
            end
         end
         QPD_DATA:
            st_nxt = QPD_DATA;
         QPD_IGNORE:
            st_nxt = QPD_IGNORE;
         default:
            st_nxt = QPD_IGNORE;
      endcase
      // one flop for the reject state, so the sync never sees a state-code glitch
      ign_nxt = (st_nxt == QPD_IGNORE);
   end

   always_ff @(posedge SCK_I or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         st_r <= QPD_ADDR;
         bit_cnt_r <= 3'd0;
         shf_r <= 7'd0;
         ign_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shf_r <= shf_nxt;
         ign_r <= ign_nxt;
      end
   end

   // instruction and toggle survive cs so the system side can pick them up
   always_ff @(posedge SCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         instr_r <= 8'h00;
         cmd_tgl_r <= 1'b0;
      end
      else
      begin
         instr_r <= instr_nxt;
         cmd_tgl_r <= cmd_tgl_nxt;
      end
   end

   // strap pins sampled in the link domain before compare
   always_ff @(posedge SCK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         strap_s1_r <= 2'b00;
         strap_s2_r <= 2'b00;
      end
      else
      begin
         strap_s1_r <= {STRAP_ADDR_HI_I, STRAP_ADDR_LO_I};
         strap_s2_r <= strap_s1_r;
      end
   end

   // ---------------- system domain ----------------
   logic [2:0] tgl_sync_r, tgl_sync_nxt;
   logic [1:0] cs_sync_r, cs_sync_nxt;
   logic cs_prev_r, cs_prev_nxt;
   logic ign_s1_r, ign_s2_r;
   logic wr_seen_r, wr_seen_nxt;
   logic cmd_valid_r, cmd_valid_nxt;
   logic [7:0] instr_sys_r, instr_sys_nxt;
   logic mism_r, mism_nxt;
   logic [22:0] nv_cnt_r, nv_cnt_nxt;
   logic nv_busy_r, nv_busy_nxt;
   logic [10:0] wp_cnt_r, wp_cnt_nxt;
   logic [7:0] pos_r [4], pos_nxt [4];
   logic [7:0] wiper_r [4], wiper_nxt [4];
   logic so_oe_r, so_oe_nxt;
   logic pend_r, pend_nxt;
   logic init_r, init_nxt;
   logic [7:0] dr0 [4];
   logic new_cmd;

   assign dr0[0] = STORED_SETTING_0_P0_I;
   assign dr0[1] = STORED_SETTING_0_P1_I;
   assign dr0[2] = STORED_SETTING_0_P2_I;
   assign dr0[3] = STORED_SETTING_0_P3_I;
   // instr_r settles at the toggle edge and holds until the next frame's
   // instruction byte, so syncing the toggle alone is enough
   assign new_cmd = tgl_sync_r[2] ^ tgl_sync_r[1];

   always_comb
   begin
      tgl_sync_nxt = {tgl_sync_r[1:0], cmd_tgl_r};
      cs_sync_nxt = {cs_sync_r[0], CS_N_I};
      cs_prev_nxt = cs_sync_r[1];
      cmd_valid_nxt = new_cmd;
      instr_sys_nxt = new_cmd ? instr_r : instr_sys_r;
      mism_nxt = ign_s2_r & ~cs_sync_r[1];
      wr_seen_nxt = wr_seen_r;
      nv_busy_nxt = nv_busy_r;
      nv_cnt_nxt = nv_cnt_r;
      pend_nxt = pend_r;
      so_oe_nxt = 1'b0;
      wp_cnt_nxt = wp_cnt_r;
      init_nxt = 1'b0;
      pos_nxt = pos_r;
      wiper_nxt = wiper_r;
      if (nv_busy_r)
      begin
         if (nv_cnt_r == 23'd0 || NV_WRITE_DONE_I)
            nv_busy_nxt = 1'b0;
         else
            nv_cnt_nxt = nv_cnt_r - 23'd1;
      end
      if (cs_sync_r[1] && !cs_prev_r)
      begin
         // start wins over a finish in the same cycle; a commit while busy restarts the count
         if (wr_seen_r)
         begin
            nv_busy_nxt = 1'b1;
            nv_cnt_nxt = 23'(NVW_CYC - 1);
         end
         wr_seen_nxt = 1'b0;
      end
      // flag any write opcode; downstream finishes the byte itself
      if (new_cmd && instr_r[QPD_OPC_MSB])
         wr_seen_nxt = 1'b1;
      if (pend_r)
      begin
         // wiper follows well inside the settle bound, even under back-to-back writes
         for (int i = 0; i < 4; i++)
            wiper_nxt[i] = pos_r[i];
         if (wp_cnt_r == 11'd0)
            pend_nxt = 1'b0;
         else
            wp_cnt_nxt = wp_cnt_r - 11'd1;
      end
      if (init_r)
      begin
         for (int i = 0; i < 4; i++)
            pos_nxt[i] = dr0[i];
         pend_nxt = 1'b1;
         wp_cnt_nxt = 11'(QPD_WIPER_CYC - 1);
      end
      else if (WIPER_WR_I)
      begin
         pos_nxt[WIPER_PTR_O] = WIPER_WR_DATA_I;
         pend_nxt = 1'b1;
         wp_cnt_nxt = 11'(QPD_WIPER_CYC - 1);
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         tgl_sync_r <= 3'b000;
         cs_sync_r <= 2'b11;
         cs_prev_r <= 1'b1;
         ign_s1_r <= 1'b0;
         ign_s2_r <= 1'b0;
         wr_seen_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         instr_sys_r <= 8'h00;
         mism_r <= 1'b0;
         nv_cnt_r <= 23'd0;
         nv_busy_r <= 1'b0;
         wp_cnt_r <= 11'd0;
         pend_r <= 1'b0;
         so_oe_r <= 1'b0;
         init_r <= 1'b1;
         for (int i = 0; i < 4; i++)
         begin
            pos_r[i] <= QPD_WIPER_RST;
            wiper_r[i] <= QPD_WIPER_RST;
         end
      end
      else
      begin
         tgl_sync_r <= tgl_sync_nxt;
         cs_sync_r <= cs_sync_nxt;
         cs_prev_r <= cs_prev_nxt;
         ign_s1_r <= ign_r;
         ign_s2_r <= ign_s1_r;
         wr_seen_r <= wr_seen_nxt;
         cmd_valid_r <= cmd_valid_nxt;
         instr_sys_r <= instr_sys_nxt;
         mism_r <= mism_nxt;
         nv_cnt_r <= nv_cnt_nxt;
         nv_busy_r <= nv_busy_nxt;
         wp_cnt_r <= wp_cnt_nxt;
         pend_r <= pend_nxt;
         so_oe_r <= so_oe_nxt;
         init_r <= init_nxt;
         pos_r <= pos_nxt;
         wiper_r <= wiper_nxt;
      end
   end

   assign CMD_VALID_O = cmd_valid_r;
   assign OPCODE_FIELD_O = instr_sys_r[QPD_OPC_MSB:QPD_OPC_LSB];
   assign SETTING_PTR_O = instr_sys_r[QPD_SET_MSB:QPD_SET_LSB];
   assign WIPER_PTR_O = instr_sys_r[QPD_WPTR_MSB:QPD_WPTR_LSB];
   assign ADDR_MISMATCH_O = mism_r;
   assign SO_OE_O = so_oe_r;
   assign WRITE_PENDING_FLAG_O = nv_busy_r;
   assign WIPER_POS0_O = wiper_r[0];
   assign WIPER_POS1_O = wiper_r[1];
   assign WIPER_POS2_O = wiper_r[2];
   assign WIPER_POS3_O = wiper_r[3];

endmodule : qpd_decode

// >>> test/qpd_decode_props.sv
// concurrent checks on the command decoder ports
`timescale 1ns/10ps
module qpd_decode_props
   import qpd_pkg::*;
#(
   parameter int NVW_CYC = QPD_NVW_CYC
)
(
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   input wire logic CS_N_I,
   input wire logic [7:0] STORED_SETTING_0_P0_I,
   input wire logic WIPER_WR_I,
   input wire logic [7:0] WIPER_WR_DATA_I,
   input wire logic CMD_VALID_O,
   input wire logic [1:0] WIPER_PTR_O,
   input wire logic ADDR_MISMATCH_O,
   input wire logic SO_OE_O,
   input wire logic WRITE_PENDING_FLAG_O,
   input wire logic [7:0] WIPER_POS0_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   int wip_cnt_r;
   int wip_cnt_nxt;
   always_comb wip_cnt_nxt = WRITE_PENDING_FLAG_O ? wip_cnt_r + 1 : 0;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
      if (!RSTN_I)
         wip_cnt_r <= 0;
      else
         wip_cnt_r <= wip_cnt_nxt;
   sequence wr0_s;
      WIPER_WR_I && WIPER_PTR_O == 2'h0;
   endsequence
   sequence pos0_new_s;
      WIPER_POS0_O == $past(WIPER_WR_DATA_I, 2);
   endsequence
   property wr_follow_p;
      wr0_s |-> ##2 pos0_new_s;
   endproperty
   so_released_a: assert property (SO_OE_O == 1'h0) else $error("output enabled");
   reject_hold_a: assert property (ADDR_MISMATCH_O && !CS_N_I |=> ADDR_MISMATCH_O) else $error("reject dropped");
   foreign_quiet_a: assert property (ADDR_MISMATCH_O |-> !CMD_VALID_O) else $error("valid on reject");
   valid_pulse_a: assert property (CMD_VALID_O |=> !CMD_VALID_O) else $error("valid too long");
   wiper_follow_a: assert property (wr_follow_p) else $error("wiper not updated");
   power_load_a: assert property ($rose(RSTN_I) |-> ##[1:3] WIPER_POS0_O == STORED_SETTING_0_P0_I)
      else $error("wiper not loaded");
   commit_start_a: assert property ($rose(WRITE_PENDING_FLAG_O) |-> CS_N_I) else $error("commit in frame");
   commit_bound_a: assert property (wip_cnt_r <= NVW_CYC + 4) else $error("commit too long");
endmodule : qpd_decode_props
bind qpd_decode qpd_decode_props #(.NVW_CYC(NVW_CYC)) i_props (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I),
   .CS_N_I(CS_N_I), .STORED_SETTING_0_P0_I(STORED_SETTING_0_P0_I), .WIPER_WR_I(WIPER_WR_I),
   .WIPER_WR_DATA_I(WIPER_WR_DATA_I), .CMD_VALID_O(CMD_VALID_O), .WIPER_PTR_O(WIPER_PTR_O),
   .ADDR_MISMATCH_O(ADDR_MISMATCH_O), .SO_OE_O(SO_OE_O), .WRITE_PENDING_FLAG_O(WRITE_PENDING_FLAG_O),
   .WIPER_POS0_O(WIPER_POS0_O));

// >>> test/qpd_spi_host.sv
// behavioural serial host, mode 0, clock still outside frames
`timescale 1ns/10ps
module qpd_spi_host
(
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o
);
   initial
   begin
      sck_o = 1'h0;
      cs_n_o = 1'h1;
      si_o = 1'h0;
   end
   task automatic xfer(input logic [15:0] w, input int half);
      cs_n_o = 1'h0;
      #(2 * half);
      for (int i = 15; i >= 0; i--)
      begin
         si_o = w[i];
         #(half) sck_o = 1'h1;
         #(half) sck_o = 1'h0;
      end
      #(half) cs_n_o = 1'h1;
      si_o = ~si_o;
      #(4 * half);
   endtask : xfer
endmodule : qpd_spi_host

// >>> test/tb_quad_pot_spi_command_decode.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
module tb_quad_pot_spi_command_decode
   import qpd_pkg::*;
   ;
   localparam int NVW = 100;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic [1:0] strap = 2'h2;
   logic [7:0] st [4] = '{8'h3C, 8'hA5, 8'h5A, 8'hC3};
   logic wr = 1'h0;
   logic [7:0] wr_data = 8'h00;
   logic nv_done = 1'h0;
   logic sck, cs_n, si, vld, mis, so_oe, write_pending_flag;
   logic [3:0] opc;
   logic [1:0] sp, wp;
   logic [7:0] pos [4];
   int fail_count = 0;
   int checked = 0;
   int vcnt = 0;
   always #4 clk = ~clk;
   always @(posedge clk)
      if (vld === 1'h1)
         vcnt++;
   qpd_spi_host i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
   qpd_decode #(.NVW_CYC(NVW)) i_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
      .STRAP_ADDR_HI_I(strap[1]), .STRAP_ADDR_LO_I(strap[0]), .STORED_SETTING_0_P0_I(st[0]),
      .STORED_SETTING_0_P1_I(st[1]), .STORED_SETTING_0_P2_I(st[2]), .STORED_SETTING_0_P3_I(st[3]),
      .WIPER_WR_I(wr), .WIPER_WR_DATA_I(wr_data), .NV_WRITE_DONE_I(nv_done), .CMD_VALID_O(vld),
      .OPCODE_FIELD_O(opc), .SETTING_PTR_O(sp), .WIPER_PTR_O(wp), .ADDR_MISMATCH_O(mis), .SO_OE_O(so_oe),
      .WRITE_PENDING_FLAG_O(write_pending_flag), .WIPER_POS0_O(pos[0]), .WIPER_POS1_O(pos[1]), .WIPER_POS2_O(pos[2]),
      .WIPER_POS3_O(pos[3]));
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'h1)
      begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] a, input logic [7:0] b);
      // link edges kept off the system clock edges
      #3;
      i_host.xfer({a, b}, 80);
      repeat (8) @(posedge clk);
   endtask : cmd
   function automatic logic [7:0] addr_b();
      return {QPD_TYPE_ID, 2'h0, strap};
   endfunction : addr_b
   task automatic t_reset;
      for (int i = 0; i < 4; i++)
         chk(pos[i] === st[i], "wiper load");
      $display("test reset done");
   endtask : t_reset
   task automatic t_decode;
      logic [7:0] b;
      int n;
      for (int k = 0; k < 16; k++)
      begin
         b = {k[3:0], k[1:0], ~k[1:0]};
         n = vcnt;
         cmd(addr_b(), b);
         chk(vcnt == n + 1, "valid count");
         chk(opc === b[7:4], "opcode");
         chk(sp === b[3:2], "setting ptr");
         chk(wp === b[1:0], "wiper ptr");
         chk(write_pending_flag === b[7], "pending");
         n = 0;
         while (write_pending_flag !== 1'h0 && n < 2 * NVW)
         begin
            @(posedge clk);
            n++;
         end
         chk(n <= NVW, "pending too long");
      end
      $display("test decode done");
   endtask : t_decode
   task automatic t_reject;
      logic [7:0] bad [3];
      int n;
      for (int s = 0; s < 4; s++)
      begin
         @(posedge clk);
         strap <= s[1:0];
         repeat (4) @(posedge clk);
         n = vcnt;
         cmd(addr_b(), {4'h9, 2'h0, s[1:0]});
         chk(vcnt == n + 1 && wp === s[1:0], "strap match");
         bad = '{{4'h6, 2'h0, s[1:0]}, {QPD_TYPE_ID, 2'h2, s[1:0]}, {QPD_TYPE_ID, 2'h0, ~s[1:0]}};
         for (int j = 0; j < 3; j++)
         begin
            fork
               cmd(bad[j], {4'hF, 2'h3, ~s[1:0]});
               #1500 chk(mis === 1'h1, "not rejected");
            join
            chk(vcnt == n + 1 && wp === s[1:0], "acted");
            chk(mis === 1'h0, "reject held after frame");
         end
      end
      $display("test reject done");
   endtask : t_reject
   task automatic t_wiper;
      logic [7:0] d;
      for (int p = 0; p < 4; p++)
      begin
         d = 8'h0F ^ {4{p[1:0]}};
         cmd(addr_b(), {4'hA, 2'h0, p[1:0]});
         @(posedge clk);
         wr <= 1'h1;
         wr_data <= d;
         nv_done <= 1'h1;
         @(posedge clk);
         wr <= 1'h0;
         nv_done <= 1'h0;
         repeat (4) @(posedge clk);
         chk(pos[p] === d, "wiper write");
         chk(write_pending_flag === 1'h0, "early done");
      end
      $display("test wiper done");
   endtask : t_wiper
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'h1;
      repeat (4) @(posedge clk);
      t_reset();
      #1000;
      t_decode();
      t_reject();
      t_wiper();
      end_sim();
   end
   initial
   begin
      #500000;
      fail_count++;
      end_sim();
   end
endmodule : tb_quad_pot_spi_command_decode
